// ---- common/profile_run_pkg.sv ----
package profile_run_pkg;
  // run states of the sequencer
  typedef enum logic [1:0] {
    ST_READY,
    ST_RUN,
    ST_HOLD,
    ST_END
  } run_state_t;

  // sampled discrete inputs, carried together
  typedef struct packed {
    logic start;
    logic reset_run;
    logic shutdown;
    logic ramp_step;
    logic fast_fwd;
    logic guar_en;
    logic hold;
  } discretes_t;

  // deviation evidence for the guaranteed soak
  typedef struct packed {
    logic dev_one;       // monitored variable one deviates
    logic dev_two;       // monitored variable two deviates
    logic clear_one;     // variable one back within limit minus hysteresis
    logic clear_two;     // variable two back within limit minus hysteresis
  } deviation_t;

  localparam int SEG_W = 6;
  localparam logic [5:0] SEG_FIRST = 6'h01;
  localparam logic [6:0] DISC_RST = 7'h00;
endpackage

// ---- rtl/profile_run_control.sv ----
`timescale 1ns/1ps
// Function
// - start rising runs from ready, end, and any hold but soak hold
// - only start rising edge acts
// - fast forward level selects accelerated run
// - guarantee hold status follows guaranteed hold
// - start assigned: reset/run rise resets to ready
// - start unassigned: reset/run fall at end runs
// - reset/run ignored while running
// - shutdown rise jumps past batch last segment
// - ramp step rise steps external ramp output
// - deviation hold when enabled and flagged
// - hold input by level or by edge style
// - soak hold releases after hysteresis clearance
// - ramp step fall leaves output soaking
module profile_run_control #(
  parameter int SEG_W = profile_run_pkg::SEG_W
) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_update,              // one update cycle strobe, same clock
  input wire profile_run_pkg::discretes_t i_disc, // raw pins
  input wire profile_run_pkg::deviation_t i_dev,  // from deviation logic
  input wire logic i_start_assigned,      // start input is assigned
  input wire logic i_hold_edge_style,     // 1: edge style hold, 0: level
  input wire logic i_ramp_external,       // segment ramp type is external
  input wire logic i_seg_is_ramp,         // current segment is a ramp
  input wire logic i_seg_check_one,       // segment_deviation_check_one
  input wire logic i_seg_check_two,       // segment_deviation_check_two
  input wire logic i_seg_done,            // segment finished
  input wire logic i_seg_last,            // current segment is the last one
  input wire logic [SEG_W-1:0] i_batch_last, // batch last segment
  output logic [1:0] o_state,
  output logic [SEG_W-1:0] o_segment,
  output logic o_fast_forward,
  output logic o_guarantee_hold_status,
  output logic o_ramp_step_pulse,
  output logic o_seg_load_pulse
);

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers and previous-sample register
  // the pins are asynchronous to i_clk_sys; one flop alone could hand a
  // metastable level to several decoders that then disagree

  profile_run_pkg::discretes_t meta_q;   // first stage, read by sync_q only
  profile_run_pkg::discretes_t sync_q;   // second stage, safe to use
  profile_run_pkg::discretes_t prev_q;   // level at last update cycle

  // two flops on every pin before any logic looks at it
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta_q <= profile_run_pkg::DISC_RST;
      sync_q <= profile_run_pkg::DISC_RST;
    end else begin
      meta_q <= i_disc;
      sync_q <= meta_q;
    end
  end

  // previous level advances only on update cycles so each edge acts once
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prev_q <= profile_run_pkg::DISC_RST;
    end else if (i_update) begin
      prev_q <= sync_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // edge and condition decode
  // a pin that toggles twice between strobes shows no edge at all, so a
  // source must hold each level for at least one update period

  wire logic [6:0] rise_w = i_update ? (sync_q & ~prev_q) : 7'h00;
  wire logic [6:0] fall_w = i_update ? (~sync_q & prev_q) : 7'h00;
  profile_run_pkg::discretes_t rise_s;
  profile_run_pkg::discretes_t fall_s;
  assign rise_s = rise_w;
  assign fall_s = fall_w;

  profile_run_pkg::run_state_t state_q, state_d;
  logic [SEG_W-1:0] seg_q, seg_d;
  logic guar_q, guar_d;                  // held by guaranteed soak

  // state decode, shared by the edge qualifiers below
  wire logic in_run = (state_q == profile_run_pkg::ST_RUN);
  wire logic in_hold = (state_q == profile_run_pkg::ST_HOLD);
  wire logic in_end = (state_q == profile_run_pkg::ST_END);
  wire logic in_ready = (state_q == profile_run_pkg::ST_READY);

  // start acts on its rising edge only; fall is never looked at
  wire logic start_go = rise_s.start & (in_ready | in_hold | in_end);
  // reset/run only outside run state
  wire logic rr_reset = rise_s.reset_run & ~in_run;
  wire logic rr_run = fall_s.reset_run & in_end & ~i_start_assigned;
  wire logic shut_go = rise_s.shutdown & (in_run | in_hold | in_end);
  // deviation hold needs enable, a deviation and its segment flag
  wire logic dev_hit = sync_q.guar_en &
    ((i_dev.dev_one & i_seg_check_one) |
     (i_dev.dev_two & i_seg_check_two));
  // released once each watched variable cleared by hysteresis
  // guar_en low also releases, so dropping the enable frees the hold
  wire logic dev_clear = (~i_seg_check_one | i_dev.clear_one) &
    (~i_seg_check_two | i_dev.clear_two) | ~sync_q.guar_en;
  // level style follows the pin; edge style latches on rise
  wire logic ext_hold_lvl = ~i_hold_edge_style & sync_q.hold;
  wire logic ext_hold_edge = i_hold_edge_style & rise_s.hold;
  // zero on the last segment, so done there ends the profile
  wire logic next_seg_w = i_seg_last ? 1'b0 : 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // next-state decode; reset and shutdown outrank holds
  // the ready and end branches both start a run; end also rewinds to
  // the first segment so a finished profile replays from its top

  // one process so the priority reads top to bottom
  always_comb begin
    state_d = state_q;
    seg_d = seg_q;
    guar_d = guar_q;
    if (!i_update) begin
      // nothing moves between update cycles
    end else if (rr_reset & i_start_assigned) begin
      state_d = profile_run_pkg::ST_READY;
      seg_d = SEG_W'(profile_run_pkg::SEG_FIRST);
      guar_d = 1'b0;
    end else if (rr_reset) begin
      // unassigned start: rising edge still resets to ready
      state_d = profile_run_pkg::ST_READY;
      seg_d = SEG_W'(profile_run_pkg::SEG_FIRST);
      guar_d = 1'b0;
    end else if (rr_run) begin
      state_d = profile_run_pkg::ST_RUN;
      seg_d = SEG_W'(profile_run_pkg::SEG_FIRST);
    end else if (shut_go) begin
      seg_d = i_batch_last + SEG_W'(1);
      state_d = profile_run_pkg::ST_RUN;
      guar_d = 1'b0;
    end else begin
      unique case (state_q)
        profile_run_pkg::ST_READY: begin
          if (start_go) state_d = profile_run_pkg::ST_RUN;
        end
        profile_run_pkg::ST_RUN: begin
          if (dev_hit) begin
            state_d = profile_run_pkg::ST_HOLD;
            guar_d = 1'b1;
          end else if (ext_hold_lvl | ext_hold_edge) begin
            state_d = profile_run_pkg::ST_HOLD;
          end else if (i_seg_done & next_seg_w) begin
            seg_d = seg_q + SEG_W'(1);
          end else if (i_seg_done) begin
            state_d = profile_run_pkg::ST_END;
          end
        end
        profile_run_pkg::ST_HOLD: begin
          if (guar_q) begin
            // soak hold ends on clearance alone
            if (dev_clear) begin
              state_d = profile_run_pkg::ST_RUN;
              guar_d = 1'b0;
            end
          end else if (!i_hold_edge_style) begin
            // level style: pin low resumes, a start rise also does
            if (!sync_q.hold | start_go) begin
              state_d = profile_run_pkg::ST_RUN;
            end
          end else if (start_go) begin
            state_d = profile_run_pkg::ST_RUN;
          end
        end
        profile_run_pkg::ST_END: begin
          if (start_go) begin
            state_d = profile_run_pkg::ST_RUN;
            seg_d = SEG_W'(profile_run_pkg::SEG_FIRST);
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state and output registers

  // the peer OR of these status bits is wired outside into i_disc.hold
  // step only on a rise; a fall is no step, so the ramp soaks meanwhile
  wire logic step_w = rise_s.ramp_step & in_run & i_ramp_external &
    i_seg_is_ramp;
  // segment reload strobe: any change of segment or a reset/run restart
  wire logic load_w = (seg_d != seg_q) | (rr_run);
  // next state is run; gates the accelerated mode
  wire logic run_d_w = (state_d == profile_run_pkg::ST_RUN);

  // outputs copy the next-state values, so they move on the same edge
  // as the state registers with no extra cycle of latency
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      // idle: ready at the first segment, all strobes low
      state_q <= profile_run_pkg::ST_READY;
      seg_q <= SEG_W'(profile_run_pkg::SEG_FIRST);
      guar_q <= 1'b0;
      o_state <= 2'h0;
      o_segment <= SEG_W'(profile_run_pkg::SEG_FIRST);
      o_fast_forward <= 1'b0;
      o_guarantee_hold_status <= 1'b0;
      o_ramp_step_pulse <= 1'b0;
      o_seg_load_pulse <= 1'b0;
    end else begin
      // every register follows its next value each clock
      state_q <= state_d;
      seg_q <= seg_d;
      guar_q <= guar_d;
      o_state <= state_d;
      o_segment <= seg_d;
      o_fast_forward <= sync_q.fast_fwd & run_d_w;
      o_guarantee_hold_status <= guar_d;
      o_ramp_step_pulse <= step_w;
      o_seg_load_pulse <= load_w;
    end
  end

endmodule

// ---- dv/run_checker.sv ----
`timescale 1ns/1ps
// port watcher for the run-state controller
module run_checker #(parameter int SEG_W = 6) (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_update,
  input wire profile_run_pkg::deviation_t i_dev,
  input wire logic i_ramp_external,
  input wire logic i_seg_is_ramp,
  input wire logic i_seg_check_one,
  input wire logic i_seg_check_two,
  input wire logic [1:0] o_state,
  input wire logic [SEG_W-1:0] o_segment,
  input wire logic o_fast_forward,
  input wire logic o_guarantee_hold_status,
  input wire logic o_ramp_step_pulse
);
  // flagged deviation, kept as a net so past sees a plain signal
  wire logic dev_hit = (i_dev.dev_one & i_seg_check_one) |
    (i_dev.dev_two & i_seg_check_two);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  ////////////////////////////////////////////////////////////////////
  // state moves only on an update strobe
  AST_STATE_ON_UPDATE: assert property (
    !i_update |=> $stable(o_state))
    else $error("state moved without an update");
  // a start out of ready lands on an update edge
  AST_RUN_FROM_READY: assert property (
    $past(o_state) == 2'h0 && o_state == 2'h1 |-> $past(i_update))
    else $error("start off update");
  // status only while held
  AST_STATUS_IN_HOLD: assert property (
    o_guarantee_hold_status |-> o_state == 2'h2)
    else $error("status high outside hold");
  // soak hold needs a flagged deviation
  AST_GUAR_ENTRY: assert property (
    $rose(o_guarantee_hold_status) |-> $past(i_update) && $past(dev_hit))
    else $error("hold without cause");
  // release only on an update
  AST_GUAR_EXIT: assert property (
    $fell(o_guarantee_hold_status) |-> $past(i_update))
    else $error("hold released off update");
  // a running profile never drops to ready
  AST_RUN_NOT_RESET: assert property (
    o_state == 2'h1 |=> o_state != 2'h0)
    else $error("run went to ready");
  // entering ready always shows the first segment
  AST_READY_SEG_ONE: assert property (
    $changed(o_state) && o_state == 2'h0 |-> o_segment == SEG_W'(1))
    else $error("ready seg bad");
  // a step needs run, an external ramp segment and an update
  AST_STEP_CAUSE: assert property (
    o_ramp_step_pulse |-> $past(i_update) && $past(i_ramp_external) &&
    $past(i_seg_is_ramp) && $past(o_state) == 2'h1)
    else $error("step without cause");
  // one step per rise, never a stretched pulse
  AST_STEP_ONE_CYCLE: assert property (
    o_ramp_step_pulse |=> !o_ramp_step_pulse)
    else $error("step pulse too long");
  // accelerated mode only while running
  AST_FF_IN_RUN: assert property (
    o_fast_forward |-> o_state == 2'h1)
    else $error("fast forward outside run");
endmodule
bind profile_run_control run_checker #(.SEG_W(SEG_W)) chk (
  .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_update(i_update),
  .i_dev(i_dev), .i_ramp_external(i_ramp_external),
  .i_seg_is_ramp(i_seg_is_ramp), .i_seg_check_one(i_seg_check_one),
  .i_seg_check_two(i_seg_check_two), .o_state(o_state),
  .o_segment(o_segment), .o_fast_forward(o_fast_forward),
  .o_ramp_step_pulse(o_ramp_step_pulse),
  .o_guarantee_hold_status(o_guarantee_hold_status));

// ---- dv/pin_source.sv ----
`timescale 1ns/1ps
// discrete pin source: levels launch just after an edge, like a contact
module pin_source (
  input wire logic i_clk_sys,
  input wire profile_run_pkg::discretes_t i_want,
  input wire logic i_status, // or of every sequencer's status output
  output profile_run_pkg::discretes_t o_pins
);
  // hold pin carries the peer or, so one soak hold stops them all
  profile_run_pkg::discretes_t drive_w;
  always_comb begin
    drive_w = i_want;
    drive_w.hold = i_want.hold | i_status;
  end
  // never change on the edge, so the sync flops see a clean level
  always @(posedge i_clk_sys) o_pins <= #1 drive_w;
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic upd = 1'b0, asg = 1'b1, ext = 1'b0, isr = 1'b0, edg = 1'b0;
  logic ck1 = 1'b0, ck2 = 1'b0, done = 1'b0, last = 1'b0, peer = 1'b0;
  profile_run_pkg::discretes_t want = profile_run_pkg::DISC_RST, pins;
  profile_run_pkg::deviation_t dev = 4'h0;
  logic [1:0] st;
  logic [5:0] seg;
  logic ff, gs, stp, ld;
  int num_errors = 0, checked = 0;
  // far side: pin levels plus the peer or of status outputs into hold
  pin_source src (.i_clk_sys(clk), .i_want(want), .i_status(gs | peer),
    .o_pins(pins));
  profile_run_control dut (.i_clk_sys(clk), .i_sys_rst(rst),
    .i_update(upd), .i_disc(pins), .i_dev(dev), .i_start_assigned(asg),
    .i_hold_edge_style(edg), .i_ramp_external(ext), .i_seg_is_ramp(isr),
    .i_seg_check_one(ck1), .i_seg_check_two(ck2), .i_seg_done(done),
    .i_seg_last(last), .i_batch_last(6'h07), .o_state(st),
    .o_segment(seg), .o_fast_forward(ff), .o_guarantee_hold_status(gs),
    .o_ramp_step_pulse(stp), .o_seg_load_pulse(ld));
  initial forever #12.5 clk = ~clk;
  // shared tally behind the compare tasks
  task tally(input logic ok, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (!ok) begin
      $display("[FAIL] %0t exp %h got %h", $time, e, g);
      num_errors++;
    end
  endtask
  task cmp_state(input logic [1:0] e);
    tally(st === e, {6'h00, e}, {6'h00, st});
  endtask
  task cmp_seg(input logic [5:0] e);
    tally(seg === e, {2'h0, e}, {2'h0, seg});
  endtask
  task cmp_bit(input logic e, input logic g);
    tally(g === e, {7'h00, e}, {7'h00, g});
  endtask
  // let pins cross source and sync, then one strobe; pulses still stand
  task step;
    repeat (4) @(posedge clk);
    #1 upd = 1'b1;
    @(posedge clk);
    #1 upd = 1'b0;
  endtask
  // start, ignored start fall and reset/run in run, fast forward level
  task run_basic;
    want.start = 1'b1;
    step;
    cmp_state(2'h1);
    want.start = 1'b0;
    want.reset_run = 1'b1;
    step;
    cmp_state(2'h1);
    want.fast_fwd = 1'b1;
    step;
    cmp_bit(1'b1, ff);
    want.fast_fwd = 1'b0;
    step;
    cmp_bit(1'b0, ff);
  endtask
  // soak hold: needs enable, holds until cleared, both watched variables
  task guar;
    dev = 4'h8;
    ck1 = 1'b1;
    step;
    cmp_state(2'h1);
    want.guar_en = 1'b1;
    step;
    cmp_state(2'h2);
    cmp_bit(1'b1, gs);
    dev = 4'h0;
    step;
    cmp_state(2'h2);
    dev = 4'h2;
    step;
    cmp_state(2'h1);
    cmp_bit(1'b0, gs);
    ck1 = 1'b0;
    ck2 = 1'b1;
    dev = 4'h4;
    step;
    cmp_state(2'h2);
    dev = 4'h1;
    step;
    cmp_state(2'h1);
    cmp_bit(1'b0, gs);
    want.guar_en = 1'b0;
    dev = 4'h0;
    ck2 = 1'b0;
  endtask
  // peer status holds by level; then edge style, resumed by start
  task hold_modes;
    peer = 1'b1;
    step;
    cmp_state(2'h2);
    cmp_bit(1'b0, gs);
    peer = 1'b0;
    step;
    cmp_state(2'h1);
    edg = 1'b1;
    want.hold = 1'b1;
    step;
    cmp_state(2'h2);
    want.hold = 1'b0;
    step;
    cmp_state(2'h2);
    want.start = 1'b1;
    step;
    cmp_state(2'h1);
    want.start = 1'b0;
    edg = 1'b0;
  endtask
  task ramp;
    ext = 1'b1;
    isr = 1'b1;
    want.ramp_step = 1'b1;
    step;
    cmp_bit(1'b1, stp);
    want.ramp_step = 1'b0;
    step;
    cmp_bit(1'b0, stp);
    ext = 1'b0;
    isr = 1'b0;
  endtask
  task shut;
    want.shutdown = 1'b1;
    step;
    cmp_seg(6'h08);
    cmp_state(2'h1);
    cmp_bit(1'b1, ld);
    want.shutdown = 1'b0;
  endtask
  // finish the last segment; reset/run stays high through the run
  task finish_seg;
    done = 1'b1;
    last = 1'b1;
    step;
    cmp_state(2'h3);
    done = 1'b0;
    last = 1'b0;
  endtask
  // reset/run at end, with start assigned and then unassigned
  task ends;
    finish_seg;
    want.reset_run = 1'b0;
    step;
    cmp_state(2'h3);
    want.reset_run = 1'b1;
    step;
    cmp_state(2'h0);
    cmp_seg(6'h01);
    cmp_bit(1'b1, ld);
    want.start = 1'b1;
    step;
    cmp_state(2'h1);
    want.start = 1'b0;
    finish_seg;
    asg = 1'b0;
    want.reset_run = 1'b0;
    step;
    cmp_state(2'h1);
    cmp_seg(6'h01);
    cmp_bit(1'b1, ld);
  endtask
  task report_and_stop;
    if (num_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    run_basic;
    guar;
    hold_modes;
    ramp;
    shut;
    ends;
    report_and_stop;
  end
  // whole run is about 120 cycles of 25 ns; ample margin before cutting it
  initial begin
    #50000;
    num_errors++;
    report_and_stop;
  end
endmodule
